/* src/dpc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dpc_host
  import dpc_pkg::*;
#(
  parameter int AW = 15,
  parameter int DW = 36
) (
  input  wire logic           core_clk,
  input  wire logic           nrst,
  input  wire logic [3:0]     reg_addr,
  input  wire logic [31:0]    reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [31:0]    reg_rdata,
  output logic                busy_out,
  output logic      [AW-1:0]  mem_addr,
  output logic      [DW-1:0]  mem_dq_o,
  output logic                mem_dq_oe_n,
  input  wire logic [DW-1:0]  mem_dq_i,
  output logic                chip_en_n,
  output logic                rw_n,
  output logic                out_en_n,
  output logic                sem_select_n,
  input  wire logic           port_busy_n,
  input  wire logic           port_int_n
);
  import dpc_pkg::*;

  if (AW < 14 || AW > 15) begin : g_aw_chk
    $error("dpc_host: address width unsupported");
  end
  if (DW < 1 || DW > 36) begin : g_dw_chk
    $error("dpc_host: data width unsupported");
  end
  if (FLOWTHRU_CYC + ACCESS_CYC > 15 || SETTLE_CYC > 15 || SOP_CYC > 15) begin : g_cnt_chk
    $error("dpc_host: timing exceeds counter");
  end

  dpc_state_t      st_r, st_nxt;
  logic [3:0]      cnt_r, cnt_nxt;
  logic [AW-1:0]   addr_r, addr_nxt;
  logic [DW-1:0]   wdat_r, wdat_nxt;
  logic [DW-1:0]   rdat_r, rdat_nxt;
  logic [3:0]      ctrl_r, ctrl_nxt;
  logic [31:0]     rd_r, rd_nxt;
  logic            ce_n_r, ce_n_nxt;
  logic            rw_n_r, rw_n_nxt;
  logic            oe_n_r, oe_n_nxt;
  logic            sem_n_r, sem_n_nxt;
  logic            dqoe_n_r, dqoe_n_nxt;
  logic            bsy_seen_r, bsy_seen_nxt;
  logic            busy_r, busy_nxt;

  function automatic logic [3:0] cyc4(input int c);
    cyc4 = (c < 1) ? 4'h1 : c[3:0];
  endfunction : cyc4

  function automatic logic [3:0] strobe_len(input logic wr);
    strobe_len = wr ? cyc4(ACCESS_CYC) : cyc4(FLOWTHRU_CYC + ACCESS_CYC);
  endfunction : strobe_len

  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    addr_nxt     = addr_r;
    wdat_nxt     = wdat_r;
    rdat_nxt     = rdat_r;
    ctrl_nxt     = ctrl_r;
    ce_n_nxt     = ce_n_r;
    rw_n_nxt     = rw_n_r;
    oe_n_nxt     = oe_n_r;
    sem_n_nxt    = sem_n_r;
    dqoe_n_nxt   = dqoe_n_r;
    bsy_seen_nxt = bsy_seen_r;
    rd_nxt       = 32'h0;
    if (reg_wr && st_r == DPC_IDLE) begin
      case (reg_addr)
        REG_ADDR:  addr_nxt = reg_wdata[AW-1:0];
        REG_WDATA: wdat_nxt = DW'(reg_wdata);
        REG_CFG:   ctrl_nxt[CTRL_SLAVE] = reg_wdata[0];
        REG_CTRL: begin
          ctrl_nxt[CTRL_WR]  = reg_wdata[CTRL_WR];
          ctrl_nxt[CTRL_SEM] = reg_wdata[CTRL_SEM];
          if (reg_wdata[CTRL_GO]) begin
            st_nxt       = DPC_SETUP;
            cnt_nxt      = cyc4(SETTLE_CYC);
            bsy_seen_nxt = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_ADDR:   rd_nxt = 32'(addr_r);
        REG_WDATA:  rd_nxt = 32'(wdat_r);
        REG_RDATA:  rd_nxt = 32'(rdat_r);
        REG_CFG:    rd_nxt = {31'h0, ctrl_r[CTRL_SLAVE]};
        REG_STATUS: rd_nxt = {28'h0, bsy_seen_r, ~port_int_n, ~port_busy_n, st_r != DPC_IDLE};
        default:    rd_nxt = 32'h0;
      endcase
    end
    case (st_r)
      DPC_IDLE: ;
      DPC_SETUP: begin
        // semaphore path keeps chip enable high; addr bits above 2 unused
        if (ctrl_r[CTRL_SEM]) sem_n_nxt = 1'b0;
        else ce_n_nxt = 1'b0;
        if (!ctrl_r[CTRL_WR]) oe_n_nxt = 1'b0;
        else dqoe_n_nxt = 1'b0;
        if (cnt_r > 4'h1) cnt_nxt = cnt_r - 4'h1;
        else begin
          // every access, slave or master, waits out SETTLE_CYC for busy to settle
          st_nxt  = DPC_STROBE;
          cnt_nxt = strobe_len(ctrl_r[CTRL_WR]);
        end
      end
      DPC_STROBE: begin
        if (!port_busy_n && !ctrl_r[CTRL_SEM]) begin
          // hold off while the port is flagged busy
          bsy_seen_nxt = 1'b1;
          rw_n_nxt     = 1'b1;
          cnt_nxt      = strobe_len(ctrl_r[CTRL_WR]);
        end else begin
          if (ctrl_r[CTRL_WR]) rw_n_nxt = 1'b0;
          if (cnt_r > 4'h1) cnt_nxt = cnt_r - 4'h1;
          else begin
            st_nxt  = DPC_HOLD;
            rdat_nxt = ctrl_r[CTRL_SEM] ? {{(DW-1){1'b0}}, mem_dq_i[0]} : mem_dq_i;
          end
        end
      end
      DPC_HOLD: begin
        rw_n_nxt   = 1'b1;
        ce_n_nxt   = 1'b1;
        sem_n_nxt  = 1'b1;
        oe_n_nxt   = 1'b1;
        st_nxt     = DPC_GAP;
        cnt_nxt    = cyc4(SOP_CYC);
      end
      DPC_GAP: begin
        dqoe_n_nxt = 1'b1;
        // deselected long enough before a semaphore read-back
        if (cnt_r > 4'h1) cnt_nxt = cnt_r - 4'h1;
        else st_nxt = DPC_IDLE;
      end
      default: st_nxt = DPC_IDLE;
    endcase
    busy_nxt = st_nxt != DPC_IDLE;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r       <= DPC_IDLE;
      cnt_r      <= 4'h0;
      addr_r     <= '0;
      wdat_r     <= '0;
      rdat_r     <= '0;
      ctrl_r     <= CFG_RST[3:0];
      rd_r       <= 32'h0;
      ce_n_r     <= 1'b1;
      rw_n_r     <= 1'b1;
      oe_n_r     <= 1'b1;
      sem_n_r    <= 1'b1;
      dqoe_n_r   <= 1'b1;
      bsy_seen_r <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      addr_r     <= addr_nxt;
      wdat_r     <= wdat_nxt;
      rdat_r     <= rdat_nxt;
      ctrl_r     <= ctrl_nxt;
      rd_r       <= rd_nxt;
      ce_n_r     <= ce_n_nxt;
      rw_n_r     <= rw_n_nxt;
      oe_n_r     <= oe_n_nxt;
      sem_n_r    <= sem_n_nxt;
      dqoe_n_r   <= dqoe_n_nxt;
      bsy_seen_r <= bsy_seen_nxt;
      busy_r     <= busy_nxt;
    end
  end

  assign reg_rdata    = rd_r;
  assign busy_out     = busy_r;
  assign mem_addr     = addr_r;
  assign mem_dq_o     = wdat_r;
  assign mem_dq_oe_n  = dqoe_n_r;
  assign chip_en_n    = ce_n_r;
  assign rw_n         = rw_n_r;
  assign out_en_n     = oe_n_r;
  assign sem_select_n = sem_n_r;
endmodule : dpc_host
`default_nettype wire

/* common/dpc_pkg.sv */
package dpc_pkg;
  // mailbox locations, both array sizes
  localparam logic [14:0] MBX_RIGHT_SMALL = 15'h3fff;
  localparam logic [14:0] MBX_LEFT_SMALL  = 15'h3ffe;
  localparam logic [14:0] MBX_RIGHT_LARGE = 15'h7fff;
  localparam logic [14:0] MBX_LEFT_LARGE  = 15'h7ffe;
  localparam int          NUM_SEMS        = 8;
  // timing in ns, 100 MHz core clock
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          ACCESS_NS       = 20;
  localparam int          FLAG_SETTLE_NS  = 20;
  localparam int          FLOWTHRU_NS     = 20;
  localparam int          SOP_NS          = 10;
  localparam int          ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SETTLE_CYC      = (FLAG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          FLOWTHRU_CYC    = (FLOWTHRU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SOP_CYC         = (SOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // own register map, word index on the command port
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_ADDR   = 4'h1;
  localparam logic [3:0]  REG_WDATA  = 4'h2;
  localparam logic [3:0]  REG_RDATA  = 4'h3;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_CFG    = 4'h5;
  // ctrl fields
  localparam int          CTRL_GO    = 0;
  localparam int          CTRL_WR    = 1;
  localparam int          CTRL_SEM   = 2;
  localparam int          CTRL_SLAVE = 3;
  localparam logic [31:0] CFG_RST    = 32'h0000_0000;
  typedef enum logic [2:0] {
    DPC_IDLE   = 3'b000,
    DPC_SETUP  = 3'b001,
    DPC_STROBE = 3'b011,
    DPC_HOLD   = 3'b010,
    DPC_GAP    = 3'b110
  } dpc_state_t;
endpackage : dpc_pkg

/* sim/dpc_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dpc_dev_model
  import dpc_pkg::*;
(
  input  wire logic [14:0] mem_addr,
  input  wire logic [35:0] mem_dq_o,
  output logic      [35:0] mem_dq_i,
  input  wire logic        chip_en_n,
  input  wire logic        rw_n,
  input  wire logic        out_en_n,
  input  wire logic        sem_select_n,
  input  wire logic        port_busy_n,
  output logic             port_int_n
);
  logic [35:0] rd, mem [0:32767];
  logic [1:0]  own [NUM_SEMS] = '{default: 2'd0};
  logic        pnd [NUM_SEMS] = '{default: 1'b0};
  logic        int_host = 1'b0, int_far = 1'b0;
  assign rd = !sem_select_n ? {35'h0, own[mem_addr[2:0]] != 2'd1} : mem[mem_addr];
  assign mem_dq_i = (!out_en_n && rw_n) ? rd : ~rd;
  assign port_int_n = !int_host;
  task automatic put(input logic [2:0] i, input logic [1:0] who, input logic v);
    if (!v && own[i] == 2'd0) own[i] = who;
    else if (own[i] != who) pnd[i] = !v;
    else if (v) {own[i], pnd[i]} = {pnd[i] ? 2'd3 - who : 2'd0, 1'b0};
  endtask : put
  // far port writes a word; this port is the left one
  task automatic far_wr(input logic [14:0] a);
    if (a == MBX_LEFT_LARGE) int_host = 1'b1;
  endtask : far_wr
  always @(negedge rw_n) #1 if (!chip_en_n) begin
    mem[mem_addr] = mem_dq_o;
    if (mem_addr == MBX_RIGHT_LARGE && port_busy_n) int_far = 1'b1;
  end else if (!sem_select_n) put(mem_addr[2:0], 2'd1, mem_dq_o[0]);
  // own mailbox read clears; the other mailbox reads untouched
  always @(negedge out_en_n) #1 if (!chip_en_n && rw_n && port_busy_n) begin
    if (mem_addr == MBX_LEFT_LARGE) int_host = 1'b0;
  end
endmodule : dpc_dev_model
`default_nettype wire

/* sim/dpc_host_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module dpc_host_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic chip_en_n,
  input wire logic rw_n,
  input wire logic out_en_n,
  input wire logic sem_select_n,
  input wire logic port_busy_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence settle_s; rw_n [*2]; endsequence
  sequence rd_wait_s; (!out_en_n && rw_n) [*3]; endsequence
  sem_alone_a: assert property (!sem_select_n |-> chip_en_n)
    else $error("sem with ce");
  wr_settle_a: assert property ($fell(chip_en_n) || $fell(sem_select_n) |-> settle_s)
    else $error("write too early");
  rd_flow_a: assert property ($fell(out_en_n) |-> rd_wait_s)
    else $error("read too short");
  sop_gap_a: assert property ($rose(sem_select_n) |=> sem_select_n)
    else $error("sem gap");
  busy_hold_a: assert property (!port_busy_n && !chip_en_n |=> rw_n)
    else $error("write under busy");
endmodule : dpc_host_chk
bind dpc_host dpc_host_chk u_dpc_host_chk (.core_clk, .nrst, .chip_en_n, .rw_n, .out_en_n,
  .sem_select_n, .port_busy_n);
`default_nettype wire

/* sim/tb_dpc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_dpc_host;
  import dpc_pkg::*;
  logic        core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, port_busy_n = 1'b1;
  logic        port_int_n, busy_out, chip_en_n, rw_n, out_en_n, sem_select_n;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, q;
  logic [14:0] mem_addr;
  logic [35:0] mem_dq_o, mem_dq_i;
  int          err_total, samples_checked, cyc;
  dpc_host u_dpc_host (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .busy_out, .mem_addr, .mem_dq_o, .mem_dq_oe_n(), .mem_dq_i, .chip_en_n, .rw_n, .out_en_n,
    .sem_select_n, .port_busy_n, .port_int_n);
  dpc_dev_model u_dpc_dev_model (.mem_addr, .mem_dq_o, .mem_dq_i, .chip_en_n, .rw_n, .out_en_n,
    .sem_select_n, .port_busy_n, .port_int_n);
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (cyc++ == 3000) complete_run(1);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) $display("CHECK FAILED %s exp %h got %h", n, e, g);
    err_total += (g !== e);
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d = 32'h0);
    @(posedge core_clk);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
    @(posedge core_clk);
    {reg_wr, reg_rd} <= 2'b00;
    #1 q = reg_rdata;
  endtask : bus
  task automatic acc(input logic [14:0] a, input logic [31:0] d, input logic [31:0] c);
    bus(1'b1, REG_ADDR, {17'h0, a});
    bus(1'b1, REG_WDATA, d);
    bus(1'b1, REG_CTRL, c);
    for (int i = 0; i < 40 && busy_out !== 1'b0; i++) #10;
    chk("busy_out", 32'h0, {31'h0, busy_out});
    bus(1'b0, REG_RDATA);
  endtask : acc
  task automatic t_mem;
    fork
      acc(15'h0042, 32'h0bad_cafe, 32'h3);
      begin
        repeat (9) @(posedge core_clk);
        port_busy_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        port_busy_n <= 1'b1;
      end
    join
    bus(1'b0, REG_STATUS);
    chk("busy seen", 32'h8, q);
    acc(15'h0042, 32'h0, 32'h1);
    chk("mem", 32'h0bad_cafe, q);
    bus(1'b0, 4'hf);
    chk("unmapped", 32'h0, q);
  endtask : t_mem
  task automatic t_sem;
    acc(15'h7ff3, 32'hffff_fffe, 32'h7);
    acc(15'h0003, 32'h0, 32'h5);
    chk("sem taken", 32'h0, {31'h0, q[0]});
    u_dpc_dev_model.put(3'd3, 2'd2, 1'b0);
    acc(15'h0003, 32'h1, 32'h7);
    acc(15'h0003, 32'h0, 32'h5);
    chk("sem handed", 32'h1, {31'h0, q[0]});
  endtask : t_sem
  task automatic t_mbx;
    u_dpc_dev_model.far_wr(MBX_LEFT_LARGE);
    bus(1'b0, REG_STATUS);
    chk("int set", 32'h4, q);
    acc(MBX_RIGHT_LARGE, 32'h0, 32'h1);
    bus(1'b0, REG_STATUS);
    chk("int kept", 32'h4, q);
    acc(MBX_RIGHT_LARGE, 32'h5a, 32'h3);
    chk("far int", 32'h1, {31'h0, u_dpc_dev_model.int_far});
    acc(MBX_LEFT_LARGE, 32'h0, 32'h1);
    bus(1'b0, REG_STATUS);
    chk("int clear", 32'h0, q);
  endtask : t_mbx
  task automatic complete_run(input int hang);
    err_total += hang;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    t_mem();
    t_sem();
    t_mbx();
    complete_run(0);
  end
endmodule : tb_dpc_host
`default_nettype wire
